/* File: hdl/rpfr_top.sv */
// fetch patch redirect unit: two armed address slots watch the cpu fetch
// address and request a branch to the fixed patch vector on a hit.
// assumes an apb master on pclk and a cpu fetch port on the same clock.
//
// Operation
// RULE1 - compare fetch address with both slots always
// RULE2 - armed hit raises request and sets hit flag
// RULE3 - request redirects fetch to fixed target f7fd
// RULE4 - enables sit at control bits 1 and 3
// RULE5 - software writes slot address only while disarmed
// RULE6 - no slot at instruction after arming
// RULE7 - no slot inside vector or call tables
// RULE8 - no slot right after flow-ending instructions
// RULE9 - slot must point at an opcode byte
// RULE10 - software loads code, addresses, then enables
// RULE11 - software puts absolute branch at target
// RULE12 - dispatch code clears hit flags by bit-test
// RULE13 - only armed and equal slots trigger
// RULE14 - reset clears both slot addresses
// RULE15 - reset clears control register to zero
// RULE16 - hit flags cannot be set by writes
// RULE17 - hit flag holds until cleared or reset
`timescale 1ns/100ps
module rpfr_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [rpfr_pkg::PADDR_W-1:0] paddr,
   input wire logic [rpfr_pkg::DATA_W-1:0] pwdata,
   output logic [rpfr_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [rpfr_pkg::FETCH_W-1:0] fetch_addr,
   input wire logic fetch_valid,
   output logic patch_branch_req,
   output logic [rpfr_pkg::FETCH_W-1:0] patch_branch_target,
   output logic irq
);

   // slot state
   logic [15:0] patch_addr_reg [rpfr_pkg::NUM_PATCH]; // slot addresses
   logic [1:0] patch_enable_reg; // arm bits per slot
   logic [1:0] patch_hit_flag_reg; // sticky hit flags per slot
   logic [1:0] patch_hit_flag_next; // next hit flags
   logic [1:0] match; // per-slot comparator outputs
   logic [1:0] hit_clear; // software clear of hit flags

   // interrupt state
   logic [1:0] irq_status_reg; // sticky event bits
   logic [1:0] irq_status_next; // next event bits
   logic [1:0] irq_mask_reg; // event enables

   // bus state
   logic pready_reg; // access-phase ready
   logic pslverr_reg; // unmapped address answer
   logic [rpfr_pkg::DATA_W-1:0] prdata_reg; // read data captured in setup
   logic [rpfr_pkg::DATA_W-1:0] rd_mux; // read data for current address
   logic rd_hit; // address is mapped

   // redirect outputs
   logic patch_branch_req_reg; // one-cycle redirect request
   logic [15:0] patch_branch_target_reg; // fixed redirect vector
   logic irq_reg; // interrupt level

   // write commit: the only edge at which a write takes effect
   logic wr_commit;
   assign wr_commit = psel && penable && pwrite && pready_reg;

   // decode helpers
   function automatic logic addr_is(input logic [rpfr_pkg::PADDR_W-1:0] a, input logic [15:0] idx);
      addr_is = (a == rpfr_pkg::idx_to_byte(idx));
   endfunction

   // pack slot arm and hit bits into the control layout
   function automatic logic [7:0] pack_ctrl(input logic [1:0] en, input logic [1:0] hit);
      logic [7:0] v;
      v = rpfr_pkg::PATCH_CTRL_RST;
      v[rpfr_pkg::CTRL_HIT0_BIT] = hit[0];
      v[rpfr_pkg::CTRL_EN0_BIT] = en[0];
      v[rpfr_pkg::CTRL_HIT1_BIT] = hit[1];
      v[rpfr_pkg::CTRL_EN1_BIT] = en[1];
      pack_ctrl = v;
   endfunction

   // one comparator per slot, always running
   for (genvar i = 0; i < rpfr_pkg::NUM_PATCH; i++) begin : g_cmp
      rpfr_cmp u_cmp (
         .patch_addr(patch_addr_reg[i]),
         .patch_enable(patch_enable_reg[i]),
         .fetch_addr(fetch_addr),
         .fetch_valid(fetch_valid),
         .match(match[i])
      ); // RULE1
   end

   // slot addresses: written whenever addressed; software keeps them
   // disarmed while writing, otherwise a stray redirect may occur
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         patch_addr_reg[0] <= rpfr_pkg::PATCH_ADDR_RST; // RULE14
         patch_addr_reg[1] <= rpfr_pkg::PATCH_ADDR_RST; // RULE14
      end else if (wr_commit && addr_is(paddr, rpfr_pkg::IDX_PATCH_ADDR0)) begin
         patch_addr_reg[0] <= pwdata[15:0]; // RULE5
      end else if (wr_commit && addr_is(paddr, rpfr_pkg::IDX_PATCH_ADDR1)) begin
         patch_addr_reg[1] <= pwdata[15:0]; // RULE5
      end
   end

   // arm bits come straight from the control write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         patch_enable_reg <= 2'h0; // RULE15
      end else if (wr_commit && addr_is(paddr, rpfr_pkg::IDX_PATCH_CTRL)) begin
         patch_enable_reg[0] <= pwdata[rpfr_pkg::CTRL_EN0_BIT]; // RULE4
         patch_enable_reg[1] <= pwdata[rpfr_pkg::CTRL_EN1_BIT]; // RULE4
      end
   end

   // writing zero to a hit bit clears it, writing one does nothing
   always_comb begin
      hit_clear = 2'h0;
      if (wr_commit && addr_is(paddr, rpfr_pkg::IDX_PATCH_CTRL)) begin
         hit_clear[0] = !pwdata[rpfr_pkg::CTRL_HIT0_BIT]; // RULE12
         hit_clear[1] = !pwdata[rpfr_pkg::CTRL_HIT1_BIT]; // RULE12
      end
   end

   // a hit in the clearing cycle wins, so no redirect goes unflagged
   always_comb begin
      patch_hit_flag_next = match | (patch_hit_flag_reg & ~hit_clear); // RULE2 RULE16 RULE17
   end

   // hit flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         patch_hit_flag_reg <= 2'h0; // RULE15
      end else begin
         patch_hit_flag_reg <= patch_hit_flag_next;
      end
   end

   // redirect request, one cycle per hitting fetch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         patch_branch_req_reg <= 1'b0;
      end else begin
         patch_branch_req_reg <= |match; // RULE2 RULE13
      end
   end

   // redirect vector held in a flop so the output is registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         patch_branch_target_reg <= rpfr_pkg::PATCH_TARGET; // RULE3
      end else begin
         patch_branch_target_reg <= rpfr_pkg::PATCH_TARGET; // RULE3
      end
   end

   // sticky event bits, write one to clear, a new hit wins
   always_comb begin
      irq_status_next = irq_status_reg;
      if (wr_commit && addr_is(paddr, rpfr_pkg::IDX_IRQ_STATUS)) begin
         irq_status_next = irq_status_reg & ~pwdata[1:0];
      end
      irq_status_next = irq_status_next | match;
   end

   // event status register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_reg <= rpfr_pkg::IRQ_RST;
      end else begin
         irq_status_reg <= irq_status_next;
      end
   end

   // event mask register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_reg <= rpfr_pkg::IRQ_RST;
      end else if (wr_commit && addr_is(paddr, rpfr_pkg::IDX_IRQ_MASK)) begin
         irq_mask_reg <= pwdata[1:0];
      end
   end

   // interrupt level, lags the status by one cycle to stay registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(irq_status_reg & irq_mask_reg);
      end
   end

   // read mux; unmapped addresses read zero with an error
   always_comb begin
      rd_mux = '0;
      rd_hit = 1'b1;
      if (addr_is(paddr, rpfr_pkg::IDX_PATCH_ADDR0)) begin
         rd_mux[15:0] = patch_addr_reg[0];
      end else if (addr_is(paddr, rpfr_pkg::IDX_PATCH_ADDR1)) begin
         rd_mux[15:0] = patch_addr_reg[1];
      end else if (addr_is(paddr, rpfr_pkg::IDX_PATCH_CTRL)) begin
         rd_mux[7:0] = pack_ctrl(patch_enable_reg, patch_hit_flag_reg);
      end else if (addr_is(paddr, rpfr_pkg::IDX_IRQ_STATUS)) begin
         rd_mux[1:0] = irq_status_reg;
      end else if (addr_is(paddr, rpfr_pkg::IDX_IRQ_MASK)) begin
         rd_mux[1:0] = irq_mask_reg;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // zero-wait slave: ready, data and error are set up in the setup cycle
   // so every answer comes from a flop; read data is a setup-time snapshot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= '0;
      end else begin
         pready_reg <= psel && !penable;
         pslverr_reg <= psel && !penable && !rd_hit;
         prdata_reg <= (psel && !penable && !pwrite) ? rd_mux : '0;
      end
   end

   // outputs
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign patch_branch_req = patch_branch_req_reg;
   assign patch_branch_target = patch_branch_target_reg;
   assign irq = irq_reg;

   // checks

   // a request follows an armed equal fetch on either slot
   a_req_needs_hit: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
      patch_branch_req |-> ($past(fetch_valid) &&
      (($past(patch_enable_reg[0]) && $past(fetch_addr) == $past(patch_addr_reg[0])) ||
      ($past(patch_enable_reg[1]) && $past(fetch_addr) == $past(patch_addr_reg[1])))))
      else $error("redirect without armed match");

   // an armed equal fetch on slot 0 requests and flags
   a_hit0_flags: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
      (fetch_valid && patch_enable_reg[0] && fetch_addr == patch_addr_reg[0])
      |=> (patch_branch_req && patch_hit_flag_reg[0]))
      else $error("slot 0 hit not flagged");

   // an armed equal fetch on slot 1 requests and flags
   a_hit1_flags: assert property (@(posedge pclk) disable iff (!presetn) // RULE1 RULE2
      (fetch_valid && patch_enable_reg[1] && fetch_addr == patch_addr_reg[1])
      |=> (patch_branch_req && patch_hit_flag_reg[1]))
      else $error("slot 1 hit not flagged");

   // request always carries the fixed target
   a_req_target: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
      patch_branch_req |-> patch_branch_target == rpfr_pkg::PATCH_TARGET)
      else $error("redirect target wrong");

   // control write lands in the enable bits
   a_enable_write: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
      (wr_commit && addr_is(paddr, rpfr_pkg::IDX_PATCH_CTRL))
      |=> (patch_enable_reg[0] == $past(pwdata[rpfr_pkg::CTRL_EN0_BIT]) &&
      patch_enable_reg[1] == $past(pwdata[rpfr_pkg::CTRL_EN1_BIT])))
      else $error("enable bits not written");

   // hit flag 0 rises only from a comparator match
   a_hit_rise_cause: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
      $rose(patch_hit_flag_reg[0]) |-> $past(match[0]))
      else $error("hit flag set without match");

   // hit flag 1 holds unless software writes the control register
   a_hit_sticky: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
      (patch_hit_flag_reg[1] && !(wr_commit && addr_is(paddr, rpfr_pkg::IDX_PATCH_CTRL)))
      |=> patch_hit_flag_reg[1])
      else $error("hit flag dropped");

   // clear by write zero works when no match coincides
   a_hit_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
      (wr_commit && addr_is(paddr, rpfr_pkg::IDX_PATCH_CTRL) && !pwdata[rpfr_pkg::CTRL_HIT0_BIT] && !match[0])
      |=> !patch_hit_flag_reg[0])
      else $error("hit flag not cleared");

   // once reset has been seen at an edge the slots and control read zero;
   // the very first edge is skipped since flops may not have seen the reset yet
   a_reset_state: assert property (@(posedge pclk) // RULE14 RULE15
      (!presetn && !$past(presetn)) |-> (patch_addr_reg[0] == rpfr_pkg::PATCH_ADDR_RST && patch_addr_reg[1] ==
      rpfr_pkg::PATCH_ADDR_RST && pack_ctrl(patch_enable_reg, patch_hit_flag_reg) == rpfr_pkg::PATCH_CTRL_RST))
      else $error("reset state wrong");

   // interrupt level follows the unmasked status one cycle later
   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      irq == $past(|(irq_status_reg & irq_mask_reg)))
      else $error("interrupt level wrong");

   // setup cycle is answered in the next cycle
   a_bus_ready: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready)
      else $error("apb answer late");

endmodule

/* File: hdl/rpfr_pkg.sv */
// package for the fetch patch redirect unit: register indices, control
// field positions, reset values and the fixed redirect target.
// assumes a 32-bit apb slave port; each register index is a word index.
package rpfr_pkg;

   // address and data widths, slot count
   localparam int unsigned FETCH_W = 16; // cpu fetch address width
   localparam int unsigned PADDR_W = 18; // apb byte address width (index * 4)
   localparam int unsigned DATA_W = 32; // apb data width
   localparam int unsigned NUM_PATCH = 2; // number of patch slots

   // register indices, byte address is four times the index
   localparam logic [15:0] IDX_PATCH_ADDR0 = 16'hff38; // patch_addr_reg_0
   localparam logic [15:0] IDX_PATCH_ADDR1 = 16'hff3a; // patch_addr_reg_1
   localparam logic [15:0] IDX_PATCH_CTRL = 16'hff8a; // patch_control_reg
   localparam logic [15:0] IDX_IRQ_STATUS = 16'hff8c; // sticky event status
   localparam logic [15:0] IDX_IRQ_MASK = 16'hff8e; // event mask

   // patch_control_reg field positions
   localparam int unsigned CTRL_HIT0_BIT = 0; // patch_hit_flag_0, cleared by writing zero
   localparam int unsigned CTRL_EN0_BIT = 1; // patch_enable_0
   localparam int unsigned CTRL_HIT1_BIT = 2; // patch_hit_flag_1, cleared by writing zero
   localparam int unsigned CTRL_EN1_BIT = 3; // patch_enable_1

   // reset values
   localparam logic [15:0] PATCH_ADDR_RST = 16'h0000;
   localparam logic [7:0] PATCH_CTRL_RST = 8'h00;
   localparam logic [1:0] IRQ_RST = 2'h0;

   // fixed redirect target holding the absolute_branch_instr
   localparam logic [15:0] PATCH_TARGET = 16'hf7fd;

   // word index to apb byte address
   function automatic logic [PADDR_W-1:0] idx_to_byte(input logic [15:0] idx);
      idx_to_byte = {idx, 2'h0};
   endfunction

endpackage

/* File: hdl/rpfr_cmp.sv */
// one patch slot comparator: flags a fetch that hits an armed address.
// assumes fetch address and strobe come from logic on the same clock.
`timescale 1ns/100ps
module rpfr_cmp (
   input wire logic [15:0] patch_addr,
   input wire logic patch_enable,
   input wire logic [15:0] fetch_addr,
   input wire logic fetch_valid,
   output logic match
);

   // a disarmed slot never hits, whatever its address holds
   always_comb begin
      match = patch_enable && fetch_valid && (patch_addr == fetch_addr); // RULE1 RULE13
   end

endmodule

/* File: tb/rpfr_cpu_model.sv */
// behavioural cpu fetch front end facing the patch redirect unit.
// assumes one clock shared with the unit; one-byte opcodes only.
`timescale 1ns/100ps
module rpfr_cpu_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic [15:0] start_addr,
   input wire logic patch_branch_req,
   input wire logic [15:0] patch_branch_target,
   output logic [15:0] fetch_addr,
   output logic fetch_valid
);
   // fetch sequencer: linear fetch, jump on a redirect request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetch_addr <= 16'h0000;
         fetch_valid <= 1'b0;
      end else if (!run) begin
         // idle: bus keeps moving so a stale value never looks valid
         fetch_valid <= 1'b0;
         fetch_addr <= ~fetch_addr;
      end else if (!fetch_valid) begin
         // first fetch of a run; every address is an opcode byte
         fetch_valid <= 1'b1;
         fetch_addr <= start_addr;
      end else if (patch_branch_req) begin
         // redirect lands on the branch slot placed by software
         fetch_addr <= patch_branch_target;
      end else begin
         fetch_addr <= fetch_addr + 16'h0001;
      end
   end
endmodule

/* File: tb/tb.sv */
// self-checking bench for the fetch patch redirect unit.
// assumes the cpu model beside it and apb tasks on pclk at 40 mhz.
`timescale 1ns/100ps
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [rpfr_pkg::PADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] fetch_addr, patch_branch_target, start_addr;
   logic fetch_valid, patch_branch_req, run;
   int miscompares = 0; // mismatch count
   int cmp_count = 0; // comparisons made
   int req_count = 0; // redirect pulses seen
   int tgt_count = 0; // fetches at the fixed target

   rpfr_top i_rpfr_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
      .patch_branch_req(patch_branch_req), .patch_branch_target(patch_branch_target), .irq(irq));
   rpfr_cpu_model i_rpfr_cpu_model (.pclk(pclk), .presetn(presetn), .run(run),
      .start_addr(start_addr), .patch_branch_req(patch_branch_req),
      .patch_branch_target(patch_branch_target), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid));

   // 25 ns clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // event monitor: count pulses and arrivals at the target
   always @(posedge pclk) begin
      if (patch_branch_req === 1'b1) req_count++;
      if (fetch_valid === 1'b1 && fetch_addr === 16'hf7fd) tgt_count++;
   end

   task automatic test_done;
      $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer; request held until pready seen high
   task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'h0};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no cycle limit here: only the watchdog ends a hung wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [15:0] idx, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, idx, d, q, e);
   endtask

   task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input logic eexp);
      logic [31:0] q;
      logic e;
      apb(1'b0, idx, 32'h0, q, e);
      chk(q, exp);
      chk({31'h0, e}, {31'h0, eexp});
   endtask

   // let the cpu model fetch linearly from a start address
   task automatic run_from(input logic [15:0] a);
      start_addr <= a;
      run <= 1'b1;
      repeat (10) @(posedge pclk);
      run <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask

   // hang guard, far beyond the roughly 130 cycles needed
   initial begin
      repeat (5000) @(posedge pclk);
      miscompares++;
      $display("ERROR at %0t: watchdog expired", $time);
      test_done;
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0;
      run = 1'b0;
      start_addr = 16'h0000;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      chk({16'h0, patch_branch_target}, 32'h0000f7fd);
      rd(rpfr_pkg::IDX_PATCH_ADDR0, 32'h0, 1'b0);
      rd(rpfr_pkg::IDX_PATCH_ADDR1, 32'h0, 1'b0);
      rd(rpfr_pkg::IDX_PATCH_CTRL, 32'h0, 1'b0);
      rd(rpfr_pkg::IDX_IRQ_STATUS, 32'h0, 1'b0);
      rd(rpfr_pkg::IDX_IRQ_MASK, 32'h0, 1'b0);
      rd(16'h0001, 32'h0, 1'b1);
      // hit flags ignore ones written by software
      wr(rpfr_pkg::IDX_PATCH_CTRL, 32'h05);
      rd(rpfr_pkg::IDX_PATCH_CTRL, 32'h0, 1'b0);
      // slot loaded while disarmed, outside the tables, on an opcode
      wr(rpfr_pkg::IDX_PATCH_ADDR0, 32'h1000);
      rd(rpfr_pkg::IDX_PATCH_ADDR0, 32'h1000, 1'b0);
      run_from(16'h0ffc);
      chk(32'(req_count), 32'd0);
      // arm slot 0 and fetch across its address
      wr(rpfr_pkg::IDX_PATCH_CTRL, 32'h02);
      run_from(16'h0ffc);
      chk(32'(req_count), 32'd1);
      chk(32'(tgt_count), 32'd1);
      rd(rpfr_pkg::IDX_PATCH_CTRL, 32'h03, 1'b0);
      rd(rpfr_pkg::IDX_IRQ_STATUS, 32'h1, 1'b0);
      chk({31'h0, irq}, 32'h0);
      // unmask, then clear the sticky event
      wr(rpfr_pkg::IDX_IRQ_MASK, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      wr(rpfr_pkg::IDX_IRQ_STATUS, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      rd(rpfr_pkg::IDX_IRQ_STATUS, 32'h0, 1'b0);
      // dispatch code clears the hit flag, enable stays
      wr(rpfr_pkg::IDX_PATCH_CTRL, 32'h02);
      rd(rpfr_pkg::IDX_PATCH_CTRL, 32'h02, 1'b0);
      // second slot: disarm, load, arm both
      wr(rpfr_pkg::IDX_PATCH_CTRL, 32'h00);
      wr(rpfr_pkg::IDX_PATCH_ADDR1, 32'h2000);
      wr(rpfr_pkg::IDX_PATCH_CTRL, 32'h0a);
      run_from(16'h1ffc);
      chk(32'(req_count), 32'd2);
      chk(32'(tgt_count), 32'd2);
      rd(rpfr_pkg::IDX_PATCH_CTRL, 32'h0e, 1'b0);
      rd(rpfr_pkg::IDX_IRQ_STATUS, 32'h2, 1'b0);
      // reset with the cpu model idle wipes slots and control
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(rpfr_pkg::IDX_PATCH_CTRL, 32'h0, 1'b0);
      rd(rpfr_pkg::IDX_IRQ_STATUS, 32'h0, 1'b0);
      rd(rpfr_pkg::IDX_PATCH_ADDR1, 32'h0, 1'b0);
      test_done;
   end
endmodule
